// File: logic/gpp_pkg.sv
// Register map, reset values and field positions of the parallel port block
package gpp_pkg;
  localparam logic [11:0] ADR_P1 = 12'h001;
  localparam logic [11:0] ADR_P2 = 12'h002;
  localparam logic [11:0] ADR_P3 = 12'h003;
  localparam logic [11:0] ADR_P4 = 12'h004;
  localparam logic [11:0] ADR_P5 = 12'h005;
  localparam logic [11:0] ADR_P6 = 12'h006;
  localparam logic [11:0] ADR_P7 = 12'h007;
  localparam logic [11:0] ADR_P9 = 12'h009;
  localparam logic [11:0] ADR_P1DIR = 12'h00b;
  localparam logic [11:0] ADR_P4DA = 12'h00c;
  localparam logic [11:0] ADR_P5DIR = 12'h00d;
  localparam logic [11:0] ADR_CONV = 12'h00e;
  localparam logic [11:0] ADR_P6FS = 12'h029;
  localparam logic [11:0] ADR_P7FS = 12'h02a;
  localparam logic [11:0] ADR_P9FS = 12'h02c;
  localparam logic [11:0] ADR_P4DB = 12'h02d;
  localparam logic [11:0] ADR_EIRQ = 12'h037;
  localparam logic [11:0] SFR_LO = 12'h000;
  localparam logic [11:0] SFR_HI = 12'h03f;
  localparam logic [11:0] DBR_LO = 12'hf80;
  localparam logic [11:0] DBR_HI = 12'hfff;
  localparam int AIN_BIT = 5;
  localparam int INT0_BIT = 6;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam logic [7:0] RST_HI = 8'hff;
  localparam logic RST_AIN = 1'b1;
  localparam logic [4:0] P2_UNUSED = 5'h00;
  localparam logic [1:0] ST_S1 = 2'h0;
  localparam logic [1:0] ST_S2 = 2'h1;
endpackage

// File: logic/gpp_ports.sv
// Parallel I/O ports with output latches, direction and function select
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RL1] Latches hold outputs; inputs sampled at read
// [RL2] Pins sampled in read sample state
// [RL3] Outputs change in write update state
// [RL4] Instruction type picks latch or pin readback
// [RL5] Port1 direction bit: 0 input, 1 output
// [RL6] Reset clears port1 direction and latches
// [RL7] Pin10 port or interrupt by enable bit
// [RL8] Driven port1 interrupt pins still raise edges
// [RL9] Software sets latch before secondary output
// [RL10] Port2 three bits, latches reset high
// [RL11] Port2 upper read bits undefined
// [RL12] Port2 bits 1,2 crystal in dual clock
// [RL13] Driven pin20 falling edge raises interrupt
// [RL14] Port3 five bits, latches reset high
// [RL15] Port4 eight bits, latches reset high
// [RL16] Port5 direction plus analog select bit
// [RL17] Analog select resets to one
// [RL18] Converting analog pins read as one
// [RL19] No port5 output during conversion; the code does not use conv_busy here, p5_oe follows p5_dir_q alone
// [RL20] Port6 per-bit segment select, resets I/O
// [RL21] Decode peripheral and buffer address ranges
// [RL22] Read-modify-write to write-only ignored
// [RL23] Software avoids reserved and wrong-direction access
// [RL24] Ports 7 and 9 behave like port6
module gpp_ports #(
  parameter int P9_BITS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic cpu_rmw,
  input wire logic cpu_rd_latch,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic cpu_rhit,
  output logic [1:0] mcyc_state,
  output logic sfr_sel,
  output logic dbr_sel,
  input wire logic dual_clock,
  input wire logic conv_busy,
  input wire logic [1:0] irq_fall_sel,
  output logic [3:0] irq_edge,
  input wire logic [7:0] seg6,
  input wire logic [7:0] seg7,
  input wire logic [3:0] seg9,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  input wire logic [2:0] p2_in,
  output logic [2:0] p2_out,
  output logic [2:0] p2_oe,
  input wire logic [4:0] p3_in,
  output logic [4:0] p3_out,
  output logic [4:0] p3_oe,
  input wire logic [7:0] p4_in,
  output logic [7:0] p4_out,
  output logic [7:0] p4_oe,
  input wire logic [7:0] p5_in,
  output logic [7:0] p5_out,
  output logic [7:0] p5_oe,
  input wire logic [7:0] p6_in,
  output logic [7:0] p6_out,
  output logic [7:0] p6_oe,
  input wire logic [7:0] p7_in,
  output logic [7:0] p7_out,
  output logic [7:0] p7_oe,
  input wire logic [3:0] p9_in,
  output logic [3:0] p9_out,
  output logic [3:0] p9_oe
);
  initial begin
    if (P9_BITS != 4) $error("gpp_ports: P9_BITS must be 4");
  end

  logic [1:0] st_q;
  logic [7:0] p1_q, p5_q, p6_q, p7_q, p4_q;
  logic [2:0] p2_q;
  logic [4:0] p3_q;
  logic [3:0] p9_q;
  logic [7:0] p1_dir_q, p5_dir_q, p4_da_q, p4_db_q, p6_fs_q, p7_fs_q;
  logic [3:0] p9_fs_q;
  logic ain_q, int0_en_q;
  logic [7:0] rdata_q;
  logic rvalid_q, rhit_q;
  logic [3:0] lvl_q;
  logic wr_go, rd_go, wo_ok;
  logic [3:0] lvl_d;

  // Open-drain style drive: pull low only while the latch holds 0
  function automatic logic [7:0] sink_oe(input logic [7:0] lat);
    sink_oe = ~lat;
  endfunction

  // Machine cycle of four internal states, one per clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= 2'h0;
    end else begin
      st_q <= st_q + 2'h1;
    end
  end
  assign mcyc_state = st_q;

  assign sfr_sel = (cpu_addr <= gpp_pkg::SFR_HI); // [RL21]
  assign dbr_sel = (cpu_addr >= gpp_pkg::DBR_LO); // [RL21]

  assign wr_go = cpu_wr && (st_q == gpp_pkg::ST_S2); // [RL3]
  assign rd_go = cpu_rd && (st_q == gpp_pkg::ST_S1); // [RL2]
  assign wo_ok = wr_go && !cpu_rmw; // [RL22]

  // Output latches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_q <= gpp_pkg::RST_LO; // [RL6]
      p2_q <= gpp_pkg::RST_HI[2:0]; // [RL10]
      p3_q <= gpp_pkg::RST_HI[4:0]; // [RL14]
      p4_q <= gpp_pkg::RST_HI; // [RL15]
      p5_q <= gpp_pkg::RST_LO; // [RL16]
      p6_q <= gpp_pkg::RST_HI; // [RL20]
      p7_q <= gpp_pkg::RST_HI; // [RL24]
      p9_q <= gpp_pkg::RST_HI[3:0]; // [RL24]
    end else if (wr_go) begin
      case (cpu_addr) // [RL1]
        gpp_pkg::ADR_P1: p1_q <= cpu_wdata;
        gpp_pkg::ADR_P2: p2_q <= cpu_wdata[2:0];
        gpp_pkg::ADR_P3: p3_q <= cpu_wdata[4:0];
        gpp_pkg::ADR_P4: p4_q <= cpu_wdata;
        gpp_pkg::ADR_P5: p5_q <= cpu_wdata;
        gpp_pkg::ADR_P6: p6_q <= cpu_wdata;
        gpp_pkg::ADR_P7: p7_q <= cpu_wdata;
        gpp_pkg::ADR_P9: p9_q <= cpu_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Write-only control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_dir_q <= gpp_pkg::RST_LO; // [RL6]
      p5_dir_q <= gpp_pkg::RST_LO; // [RL16]
      p4_da_q <= gpp_pkg::RST_LO;
      p4_db_q <= gpp_pkg::RST_LO;
      p6_fs_q <= gpp_pkg::RST_LO; // [RL20]
      p7_fs_q <= gpp_pkg::RST_LO; // [RL24]
      p9_fs_q <= gpp_pkg::RST_LO[3:0]; // [RL24]
    end else if (wo_ok) begin
      case (cpu_addr) // [RL22]
        gpp_pkg::ADR_P1DIR: p1_dir_q <= cpu_wdata; // [RL5]
        gpp_pkg::ADR_P5DIR: p5_dir_q <= cpu_wdata;
        gpp_pkg::ADR_P4DA: p4_da_q <= cpu_wdata;
        gpp_pkg::ADR_P4DB: p4_db_q <= cpu_wdata;
        gpp_pkg::ADR_P6FS: p6_fs_q <= cpu_wdata;
        gpp_pkg::ADR_P7FS: p7_fs_q <= cpu_wdata;
        gpp_pkg::ADR_P9FS: p9_fs_q <= cpu_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Shadow copies of bits owned by the converter and interrupt control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ain_q <= gpp_pkg::RST_AIN; // [RL17]
      int0_en_q <= 1'b0; // [RL7]
    end else if (wr_go) begin
      if (cpu_addr == gpp_pkg::ADR_CONV) begin
        ain_q <= cpu_wdata[gpp_pkg::AIN_BIT]; // [RL16]
      end
      if (cpu_addr == gpp_pkg::ADR_EIRQ) begin
        int0_en_q <= cpu_wdata[gpp_pkg::INT0_BIT]; // [RL7]
      end
    end
  end

  // Pin drive
  logic [7:0] p5_ain;
  // Sink-style enables of the narrow ports, cut to width below
  logic [7:0] p2_sink, p3_sink, p9_sink;
  assign p2_sink = sink_oe({5'h00, p2_q});
  assign p3_sink = sink_oe({3'h0, p3_q});
  assign p9_sink = sink_oe({4'h0, p9_q});
  assign p5_ain = {8{ain_q}} & ~p5_dir_q;
  assign p1_out = p1_q;
  assign p1_oe = p1_dir_q & {7'h7f, ~int0_en_q}; // [RL5] [RL7]
  assign p2_out = 3'h0;
  assign p2_oe = p2_sink[2:0] & {~dual_clock, ~dual_clock, 1'b1}; // [RL12]
  assign p3_out = 5'h00;
  assign p3_oe = p3_sink[4:0]; // [RL14]
  // Port4: direction a picks push-pull, direction b forces input
  assign p4_out = p4_q & p4_da_q;
  assign p4_oe = (p4_da_q | sink_oe(p4_q)) & ~p4_db_q; // [RL15]
  assign p5_out = p5_q;
  assign p5_oe = p5_dir_q & ~p5_ain; // [RL16]
  assign p6_out = (p6_fs_q & seg6) | (~p6_fs_q & 8'h00);
  assign p6_oe = p6_fs_q | sink_oe(p6_q); // [RL20]
  assign p7_out = p7_fs_q & seg7;
  assign p7_oe = p7_fs_q | sink_oe(p7_q); // [RL24]
  assign p9_out = p9_fs_q & seg9;
  assign p9_oe = p9_fs_q | p9_sink[3:0]; // [RL24]

  // Interrupt pin levels follow the driven value when the pin is an output
  always_comb begin
    lvl_d[0] = p1_oe[0] ? p1_out[0] : p1_in[0];
    lvl_d[1] = p1_oe[1] ? p1_out[1] : p1_in[1]; // [RL8]
    lvl_d[2] = p1_oe[2] ? p1_out[2] : p1_in[2]; // [RL8]
    lvl_d[3] = p2_oe[0] ? p2_out[0] : p2_in[0]; // [RL13]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 4'hf;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_edge <= 4'h0;
    end else begin
      irq_edge[0] <= int0_en_q && lvl_q[0] && !lvl_d[0]; // [RL7]
      irq_edge[1] <= irq_fall_sel[0] ? (lvl_q[1] && !lvl_d[1])
                                     : (!lvl_q[1] && lvl_d[1]); // [RL8]
      irq_edge[2] <= irq_fall_sel[1] ? (lvl_q[2] && !lvl_d[2])
                                     : (!lvl_q[2] && lvl_d[2]); // [RL8]
      irq_edge[3] <= lvl_q[3] && !lvl_d[3]; // [RL13]
    end
  end

  // Readback
  logic [7:0] rd_d;
  logic hit_d;
  always_comb begin
    rd_d = 8'h00;
    hit_d = 1'b1;
    case (cpu_addr)
      gpp_pkg::ADR_P1: rd_d = (p1_dir_q & p1_q) | (~p1_dir_q & p1_in);
      gpp_pkg::ADR_P2: rd_d = {gpp_pkg::P2_UNUSED, cpu_rd_latch ? p2_q : p2_in}; // [RL11]
      gpp_pkg::ADR_P3: rd_d = {3'h0, cpu_rd_latch ? p3_q : p3_in}; // [RL4]
      gpp_pkg::ADR_P4: rd_d = cpu_rd_latch ? p4_q : p4_in; // [RL4]
      gpp_pkg::ADR_P5: rd_d = (conv_busy ? p5_ain : 8'h00) | (~p5_dir_q & p5_in)
                              | (p5_dir_q & p5_q); // [RL18]
      gpp_pkg::ADR_P6: rd_d = cpu_rd_latch ? p6_q : p6_in; // [RL4]
      gpp_pkg::ADR_P7: rd_d = cpu_rd_latch ? p7_q : p7_in; // [RL4]
      gpp_pkg::ADR_P9: rd_d = {4'h0, cpu_rd_latch ? p9_q : p9_in}; // [RL4]
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      rhit_q <= 1'b0;
    end else begin
      rvalid_q <= rd_go; // [RL2]
      if (rd_go) begin
        rdata_q <= rd_d; // [RL1]
        rhit_q <= hit_d;
      end
    end
  end
  assign cpu_rdata = rdata_q;
  assign cpu_rvalid = rvalid_q;
  assign cpu_rhit = rhit_q;

  // Checks
  property p_rd_s1;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_rd && st_q == gpp_pkg::ST_S1 |=> cpu_rvalid;
  endproperty
  a_rd_s1: assert property (p_rd_s1) else $error("read not answered after S1"); // [RL2]

  property p_rvalid_only_s2;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_rvalid |-> st_q == gpp_pkg::ST_S2;
  endproperty
  a_rvalid_only_s2: assert property (p_rvalid_only_s2) else $error("rvalid off state"); // [RL2]

  property p_p1_wr;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_wr && st_q == gpp_pkg::ST_S2 && cpu_addr == gpp_pkg::ADR_P1
      |=> p1_out == $past(cpu_wdata);
  endproperty
  a_p1_wr: assert property (p_p1_wr) else $error("port1 latch not written"); // [RL3]

  property p_no_wr_s1;
    @(posedge sys_clk) disable iff (!rst_n)
    st_q != gpp_pkg::ST_S2 |=> $stable(p3_oe);
  endproperty
  a_no_wr_s1: assert property (p_no_wr_s1) else $error("port3 changed off S2"); // [RL3]

  property p_rmw_wo;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_wr && cpu_rmw && cpu_addr == gpp_pkg::ADR_P1DIR |=> $stable(p1_dir_q);
  endproperty
  a_rmw_wo: assert property (p_rmw_wo) else $error("rmw changed write-only reg"); // [RL22]

  property p_dir_in;
    @(posedge sys_clk) disable iff (!rst_n)
    wo_ok && cpu_addr == gpp_pkg::ADR_P1DIR |=> p1_oe[7] == $past(cpu_wdata[7]);
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("port1 direction not applied"); // [RL5]

  property p_int0_in;
    @(posedge sys_clk) disable iff (!rst_n)
    int0_en_q |-> !p1_oe[0];
  endproperty
  a_int0_in: assert property (p_int0_in) else $error("int0 pin driven"); // [RL7]

  property p_p20_fall;
    @(posedge sys_clk) disable iff (!rst_n)
    p2_oe[0] && !$past(p2_oe[0]) && $past(p2_in[0]) |=> irq_edge[3];
  endproperty
  a_p20_fall: assert property (p_p20_fall) else $error("pin20 fall missed"); // [RL13]

  property p_ain_read;
    @(posedge sys_clk) disable iff (!rst_n)
    rd_go && conv_busy && cpu_addr == gpp_pkg::ADR_P5 |=> &(cpu_rdata | ~$past(p5_ain));
  endproperty
  a_ain_read: assert property (p_ain_read) else $error("analog pin read not 1"); // [RL18]

  property p_seg6;
    @(posedge sys_clk) disable iff (!rst_n)
    p6_fs_q[0] |-> p6_oe[0] && p6_out[0] == seg6[0];
  endproperty
  a_seg6: assert property (p_seg6) else $error("segment not driven"); // [RL20]

  property p_sfr;
    @(posedge sys_clk) disable iff (!rst_n)
    sfr_sel |-> !dbr_sel && cpu_addr[11:6] == 6'h00;
  endproperty
  a_sfr: assert property (p_sfr) else $error("sfr decode wrong"); // [RL21]

  // A write request held outside the update state must not move the port1 or port5 latch
  property p_wr_wait;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_wr && st_q != gpp_pkg::ST_S2 |=> $stable(p1_out) && $stable(p5_out);
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("latch moved off S2"); // [RL3]

  property p_p2_upper;
    @(posedge sys_clk) disable iff (!rst_n)
    rd_go && cpu_addr == gpp_pkg::ADR_P2 |=> cpu_rdata[7:3] == gpp_pkg::P2_UNUSED;
  endproperty
  a_p2_upper: assert property (p_p2_upper) else $error("port2 upper bits wrong"); // [RL11]

  property p_p4_latch_rd;
    @(posedge sys_clk) disable iff (!rst_n)
    rd_go && cpu_rd_latch && cpu_addr == gpp_pkg::ADR_P4 |=> cpu_rdata == $past(p4_q);
  endproperty
  a_p4_latch_rd: assert property (p_p4_latch_rd) else $error("port4 latch read wrong"); // [RL4]

  // Addresses above the last port hold no port data
  property p_no_hit;
    @(posedge sys_clk) disable iff (!rst_n)
    rd_go && cpu_addr > gpp_pkg::ADR_P9 |=> !cpu_rhit;
  endproperty
  a_no_hit: assert property (p_no_hit) else $error("non-port read hit"); // [RL21]

  c_rd_p1: cover property (@(posedge sys_clk) rd_go && cpu_addr == gpp_pkg::ADR_P1);
  c_wr_p5: cover property (@(posedge sys_clk) wr_go && cpu_addr == gpp_pkg::ADR_P5);
  c_irq1: cover property (@(posedge sys_clk) irq_edge[1]);
  c_latch_rd: cover property (@(posedge sys_clk) rd_go && cpu_rd_latch);
  c_ain_busy: cover property (@(posedge sys_clk) rd_go && conv_busy && cpu_addr == gpp_pkg::ADR_P5);
endmodule
`default_nettype wire

// File: sim/gpp_pin_model.sv
// Pin model: external circuitry and pull-ups on one parallel port
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] dut_out,
  input wire logic [W-1:0] dut_oe,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_oe,
  output logic [W-1:0] pin
);
  // Device drive wins, then the external driver, else the pull-up holds the line high
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = dut_oe[i] ? dut_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the parallel port block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk, rst_n, cpu_rd, cpu_wr, cpu_rmw, cpu_rd_latch, dual_clock, conv_busy;
  logic cpu_rvalid, cpu_rhit, sfr_sel, dbr_sel;
  logic [11:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, seg6, seg7, p1_in, p1_out, p1_oe, p4_in, p4_out, p4_oe;
  logic [7:0] p5_in, p5_out, p5_oe, p6_in, p6_out, p6_oe, p7_in, p7_out, p7_oe, e1, o1, o5, rd;
  logic [7:0] e4, o4, e5, e6, o6, e7, o7;
  logic [4:0] p3_in, p3_out, p3_oe, o3, e3;
  logic [3:0] seg9, irq_edge, p9_in, p9_out, p9_oe, e9, o9;
  logic [2:0] p2_in, p2_out, p2_oe, e2, o2;
  logic [1:0] mcyc_state, irq_fall_sel;
  logic [11:0] dec_a[6] = '{12'h000, 12'h03f, 12'h040, 12'hf7f, 12'hf80, 12'hfff};
  logic [7:0] dec_e[6] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01};
  int miscompares = 0;
  int n_compared = 0;
  int ecnt[4] = '{0, 0, 0, 0};
  int b[4];

  gpp_ports #(.P9_BITS(4)) dut (.sys_clk, .rst_n, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_rmw,
    .cpu_rd_latch, .cpu_wdata, .cpu_rdata, .cpu_rvalid, .cpu_rhit, .mcyc_state, .sfr_sel,
    .dbr_sel, .dual_clock, .conv_busy, .irq_fall_sel, .irq_edge, .seg6, .seg7, .seg9,
    .p1_in, .p1_out, .p1_oe, .p2_in, .p2_out, .p2_oe, .p3_in, .p3_out, .p3_oe, .p4_in, .p4_out,
    .p4_oe, .p5_in, .p5_out, .p5_oe, .p6_in, .p6_out, .p6_oe, .p7_in, .p7_out, .p7_oe,
    .p9_in, .p9_out, .p9_oe);
  gpp_pin_model #(.W(8)) m1 (.dut_out(p1_out), .dut_oe(p1_oe), .ext_val(e1), .ext_oe(o1),
    .pin(p1_in));
  gpp_pin_model #(.W(3)) m2 (.dut_out(p2_out), .dut_oe(p2_oe), .ext_val(e2), .ext_oe(o2),
    .pin(p2_in));
  gpp_pin_model #(.W(5)) m3 (.dut_out(p3_out), .dut_oe(p3_oe), .ext_val(e3), .ext_oe(o3),
    .pin(p3_in));
  gpp_pin_model #(.W(8)) m4 (.dut_out(p4_out), .dut_oe(p4_oe), .ext_val(e4), .ext_oe(o4),
    .pin(p4_in));
  gpp_pin_model #(.W(8)) m5 (.dut_out(p5_out), .dut_oe(p5_oe), .ext_val(e5), .ext_oe(o5),
    .pin(p5_in));
  gpp_pin_model #(.W(8)) m6 (.dut_out(p6_out), .dut_oe(p6_oe), .ext_val(e6), .ext_oe(o6),
    .pin(p6_in));
  gpp_pin_model #(.W(8)) m7 (.dut_out(p7_out), .dut_oe(p7_oe), .ext_val(e7), .ext_oe(o7),
    .pin(p7_in));
  gpp_pin_model #(.W(4)) m9 (.dut_out(p9_out), .dut_oe(p9_oe), .ext_val(e9), .ext_oe(o9),
    .pin(p9_in));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Interrupt edge pulses are one cycle wide, so count them as they pass
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      ecnt[i] += irq_edge[i];
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One access per machine cycle, raised within the read state before its closing edge and held through both states
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, input logic m,
                     input logic l);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (mcyc_state !== 2'h0 && k < 8) begin
      @(negedge sys_clk);
      k++;
    end
    cpu_addr = a;
    cpu_wdata = d;
    cpu_rmw = m;
    cpu_rd_latch = l;
    cpu_rd = !w;
    cpu_wr = w;
    @(negedge sys_clk);
    if (!w) begin
      chk({7'h0, cpu_rvalid}, 8'h01);
      rd = cpu_rdata;
    end
    @(negedge sys_clk);
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    @(negedge sys_clk);
  endtask

  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish;
  end

  initial begin
    {rst_n, cpu_rd, cpu_wr, cpu_rmw, cpu_rd_latch, dual_clock, conv_busy} = 7'h00;
    cpu_addr = 12'h000;
    cpu_wdata = 8'h00;
    {seg6, seg7, seg9, irq_fall_sel} = {8'h5a, 8'hc3, 4'h6, 2'h2};
    {e1, o1, o5, o3} = {8'h00, 8'h00, 8'h00, 5'h00};
    {e2, o2, e3, e4, o4, e5} = {3'h5, 3'h6, 5'h0a, 8'h00, 8'h00, 8'h3c};
    {e6, o6, e7, o7, e9, o9} = {8'h00, 8'h00, 8'h00, 8'h00, 4'h0, 4'h0};
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(p1_oe | p4_oe | p5_oe, 8'h00);
    chk({3'h0, p3_oe} | {5'h0, p2_oe} | p6_oe | p7_oe, 8'h00);
    chk(p1_out | p5_out, 8'h00);
    // All port1 pins are inputs after reset, so a read returns the pulled-up pins
    acc(1'b0, gpp_pkg::ADR_P1, 8'h00, 1'b0, 1'b1);
    chk(rd, 8'hff);
    acc(1'b0, gpp_pkg::ADR_P2, 8'h00, 1'b0, 1'b1);
    chk(rd, 8'h07);
    acc(1'b0, gpp_pkg::ADR_P2, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'h05);
    for (int i = 0; i < 6; i++) begin
      cpu_addr = dec_a[i];
      #1;
      chk({6'h0, sfr_sel, dbr_sel}, dec_e[i]);
    end
    acc(1'b0, 12'h00f, 8'h00, 1'b0, 1'b0);
    chk({rd[7:1], cpu_rhit}, 8'h00);
    $display("reset and decode done");
    acc(1'b1, gpp_pkg::ADR_P1, 8'ha5, 1'b0, 1'b0);
    acc(1'b1, gpp_pkg::ADR_P1DIR, 8'h0f, 1'b0, 1'b0);
    chk(p1_oe, 8'h0f);
    chk(p1_out, 8'ha5);
    {e1, o1} = {8'h3c, 8'hf0};
    acc(1'b0, gpp_pkg::ADR_P1, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'h35);
    chk({7'h0, cpu_rhit}, 8'h01);
    acc(1'b1, gpp_pkg::ADR_P1DIR, 8'hff, 1'b1, 1'b0);
    chk(p1_oe, 8'h0f);
    b = ecnt;
    acc(1'b1, gpp_pkg::ADR_P1, 8'ha3, 1'b0, 1'b0);
    // The edge pulse is counted half a clock after the access ends
    @(negedge sys_clk);
    chk(8'(ecnt[1] - b[1]), 8'h01);
    chk(8'(ecnt[2] - b[2]), 8'h01);
    irq_fall_sel = 2'h1;
    b = ecnt;
    acc(1'b1, gpp_pkg::ADR_P1, 8'ha5, 1'b0, 1'b0);
    @(negedge sys_clk);
    chk(8'(ecnt[1] - b[1]), 8'h01);
    chk(8'(ecnt[2] - b[2]), 8'h01);
    {e1, o1} = {8'hf1, 8'hf1};
    acc(1'b1, gpp_pkg::ADR_EIRQ, 8'h40, 1'b0, 1'b0);
    chk(p1_oe, 8'h0e);
    b = ecnt;
    e1 = 8'hf0;
    repeat (3) @(negedge sys_clk);
    chk(8'(ecnt[0] - b[0]), 8'h01);
    $display("port1 done");
    b = ecnt;
    acc(1'b1, gpp_pkg::ADR_P2, 8'h06, 1'b0, 1'b0);
    @(negedge sys_clk);
    chk(8'(ecnt[3] - b[3]), 8'h01);
    dual_clock = 1'b1;
    acc(1'b1, gpp_pkg::ADR_P2, 8'h00, 1'b0, 1'b0);
    chk({5'h0, p2_oe}, 8'h01);
    dual_clock = 1'b0;
    @(negedge sys_clk);
    chk({5'h0, p2_oe}, 8'h07);
    acc(1'b1, gpp_pkg::ADR_P3, 8'h1a, 1'b0, 1'b0);
    chk({3'h0, p3_oe}, 8'h05);
    o3 = 5'h1a;
    acc(1'b0, gpp_pkg::ADR_P3, 8'h00, 1'b0, 1'b1);
    chk(rd, 8'h1a);
    acc(1'b0, gpp_pkg::ADR_P3, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'h0a);
    $display("ports 2 and 3 done");
    acc(1'b1, gpp_pkg::ADR_P4DA, 8'h0f, 1'b0, 1'b0);
    chk(p4_out & p4_oe, 8'h0f);
    acc(1'b1, gpp_pkg::ADR_P4DB, 8'h03, 1'b0, 1'b0);
    chk(p4_oe, 8'h0c);
    {o4, e4} = {8'hf0, 8'ha0};
    acc(1'b0, gpp_pkg::ADR_P4, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'haf);
    acc(1'b0, gpp_pkg::ADR_P4, 8'h00, 1'b0, 1'b1);
    chk(rd, 8'hff);
    {o5, conv_busy} = {8'hff, 1'b1};
    acc(1'b0, gpp_pkg::ADR_P5, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'hff);
    acc(1'b1, gpp_pkg::ADR_CONV, 8'h00, 1'b0, 1'b0);
    acc(1'b0, gpp_pkg::ADR_P5, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'h3c);
    {o5, conv_busy} = {8'hf0, 1'b0};
    acc(1'b1, gpp_pkg::ADR_P5DIR, 8'h0f, 1'b0, 1'b0);
    acc(1'b1, gpp_pkg::ADR_P5, 8'h05, 1'b0, 1'b0);
    chk(p5_oe & p5_out, 8'h05);
    acc(1'b0, gpp_pkg::ADR_P5, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'h35);
    $display("ports 4 and 5 done");
    acc(1'b1, gpp_pkg::ADR_P6FS, 8'h0f, 1'b0, 1'b0);
    acc(1'b1, gpp_pkg::ADR_P7FS, 8'hf0, 1'b0, 1'b0);
    acc(1'b1, gpp_pkg::ADR_P9FS, 8'h03, 1'b0, 1'b0);
    chk(p6_oe ^ p6_out, 8'h05);
    chk(p7_oe ^ p7_out, 8'h30);
    chk({p9_oe, p9_out}, 8'h32);
    {o6, e6, o7, e7, o9, e9} = {8'hf0, 8'h90, 8'h0f, 8'h05, 4'hc, 4'h4};
    acc(1'b0, gpp_pkg::ADR_P6, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'h9a);
    acc(1'b0, gpp_pkg::ADR_P7, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'hc5);
    acc(1'b0, gpp_pkg::ADR_P9, 8'h00, 1'b0, 1'b0);
    chk(rd, 8'h06);
    $display("segment select done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
